// File: verilog/sro_params.svh
// constants of the serial readout converter control block
// assumes inclusion by bare name from the package and sro_adc_top
`ifndef SRO_PARAMS_SVH
`define SRO_PARAMS_SVH

// ******************************************************
// word and lane layout
// ******************************************************
`define SRO_WORD_W 16
`define SRO_EDGE_W 4
`define SRO_PAT_SINGLE 16'ha07f
`define SRO_PAT_DUAL 16'hcc3f

// ******************************************************
// pin synchroniser
// ******************************************************
`define SRO_SYNC_STAGES 3
`define SRO_PIN_COUNT 5
`define SRO_PIN_STROBE 0
`define SRO_PIN_PD_N 1
`define SRO_PIN_DUAL 2
`define SRO_PIN_PAT 3
`define SRO_PIN_SUPPLY 4
// level of each pin synchroniser while reset holds: all low, so power-down and low supply read active
`define SRO_PIN_RESET 5'h00

// ******************************************************
// timing
// ******************************************************
`define SRO_CORE_CLK_MHZ 25
`define SRO_CONV_TIME_NS 63
`define SRO_CONV_CYC_RAW (`SRO_CONV_TIME_NS * `SRO_CORE_CLK_MHZ / 1000)
`define SRO_CONV_CYC ((`SRO_CONV_CYC_RAW > 0) ? `SRO_CONV_CYC_RAW : 1)
`define SRO_CNT_W 4
`define SRO_INVALID_RESULTS 2
`define SRO_SUSPECT_W 2
`define SRO_SETTLE_TIME_MS 20

`endif

// File: verilog/sro_pkg.sv
// types shared by the converter control core and its link serializer
// assumes sro_params.svh is on the include path
`include "sro_params.svh"

package sro_pkg;

   // ******************************************************
   // types
   // ******************************************************
   typedef logic [`SRO_WORD_W-1:0] sro_word_t;
   typedef logic [`SRO_EDGE_W-1:0] sro_edge_t;

   // gray coded along off -> idle -> convert -> idle
   typedef enum logic [1:0] {
      SRO_ST_OFF = 2'b00,
      SRO_ST_IDLE = 2'b01,
      SRO_ST_CONV = 2'b11
   } sro_state_e;

endpackage

// File: verilog/sro_link_if.sv
// carrier between the core clock domain and the readout clock domain
// assumes the core side holds word, mode and clear quasi static
interface sro_link_if;
   import sro_pkg::*;

   sro_word_t word;
   logic dual;
   logic clear;
   logic lane_a;
   logic lane_b;

   // core domain drives the word to send and reads the lane bits back
   modport core (
      output word,
      output dual,
      output clear,
      input lane_a,
      input lane_b
   );

   // readout domain shifts the word out on both clock edges
   modport link (
      input word,
      input dual,
      input clear,
      output lane_a,
      output lane_b
   );
endinterface

// File: verilog/sro_serializer.sv
// dual edge serializer running on the host readout clock
// assumes word and dual stay stable during a burst; clear is a core flop
module sro_serializer (
   input wire logic readout_clk,
   sro_link_if.link lnk
);
   import sro_pkg::*;

   // ******************************************************
   // edge counters
   // ******************************************************
   // one counter per clock edge; their sum is the count of edges seen.
   // both wrap at sixteen, so the sum stays right across word borders
   // without either domain touching the other counter.
   sro_edge_t rise_cnt_ff;
   sro_edge_t fall_cnt_ff;
   sro_edge_t edge_sum;
   logic [2:0] pair_idx;
   logic [3:0] bit_a_idx;
   logic [3:0] bit_b_idx;

   // rising edge count; the link clock may stop, so the reset is async
   always_ff @(posedge readout_clk or posedge lnk.clear) begin
      if (lnk.clear) begin
         rise_cnt_ff <= 4'h0;
      end else begin
         rise_cnt_ff <= rise_cnt_ff + 4'h1;
      end
   end

   // falling edge count
   always_ff @(negedge readout_clk or posedge lnk.clear) begin
      if (lnk.clear) begin
         fall_cnt_ff <= 4'h0;
      end else begin
         fall_cnt_ff <= fall_cnt_ff + 4'h1;
      end
   end

   // ******************************************************
   // bit selection
   // ******************************************************
   // msb first; in two lane mode lane a takes the upper bit of a pair
   assign edge_sum = rise_cnt_ff + fall_cnt_ff;
   assign pair_idx = edge_sum[2:0];
   assign bit_a_idx = lnk.dual ? (4'hf - {pair_idx, 1'b0}) :
                      (4'hf - edge_sum);
   assign bit_b_idx = 4'he - {pair_idx, 1'b0};
   assign lnk.lane_a = lnk.word[bit_a_idx];
   assign lnk.lane_b = lnk.dual & lnk.word[bit_b_idx];
endmodule

// File: verilog/sro_adc_top.sv
// control and serial readout core of a 16 bit sampling converter
// assumes the analog core presents its settled code on analog_code and a
// supply monitor level on supply_ok; the host owns readout_clk
`include "sro_params.svh"

module sro_adc_top #(
   parameter int WORD_W = `SRO_WORD_W,
   parameter int INVALID_RESULTS = `SRO_INVALID_RESULTS
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic readout_clk,
   input wire logic convert_strobe,
   input wire logic power_down_n,
   input wire logic dual_lane_select,
   input wire logic pattern_force,
   input wire logic supply_ok,
   input wire sro_pkg::sro_word_t analog_code,
   output logic lane_a_out,
   output logic lane_a_oe,
   output logic lane_b_out,
   output logic lane_b_oe,
   output logic echoed_clock_out,
   output logic echo_oe,
   output logic result_suspect,
   output logic conversion_busy
);
   import sro_pkg::*;

   // ******************************************************
   // declarations
   // ******************************************************
   localparam int PINS = `SRO_PIN_COUNT;
   localparam int STAGES = `SRO_SYNC_STAGES;
   localparam logic [`SRO_CNT_W-1:0] CONV_LAST =
      `SRO_CNT_W'(`SRO_CONV_CYC - 1);
   localparam logic [`SRO_SUSPECT_W-1:0] SUSPECT_LIMIT =
      `SRO_SUSPECT_W'(INVALID_RESULTS);

   sro_link_if lnk ();

   // pin synchronisers and the accepted level of each pin
   logic [STAGES-1:0] sync_ff [PINS];
   logic [PINS-1:0] pin_lvl_ff;
   logic [PINS-1:0] nxt_pin_lvl;

   logic strobe_lvl;
   logic pd_n_lvl;
   logic dual_lvl;
   logic pat_lvl;
   logic supply_lvl;

   logic strobe_prev_ff;
   logic strobe_rise;
   logic hold_off;

   sro_state_e state_ff;
   sro_state_e nxt_state;
   logic [`SRO_CNT_W-1:0] conv_cnt_ff;
   logic [`SRO_CNT_W-1:0] nxt_conv_cnt;
   logic conv_start;
   logic conv_done;

   sro_word_t sample_ff;
   sro_word_t result_ff;
   sro_word_t word_ff;
   sro_word_t nxt_word;
   sro_word_t pattern_word;

   logic [`SRO_SUSPECT_W-1:0] done_cnt_ff;
   logic [`SRO_SUSPECT_W-1:0] nxt_done_cnt;
   logic suspect_ff;
   logic nxt_suspect;

   logic dual_ff;
   logic dual_change;
   logic clear_ff;
   logic lanes_on_ff;
   logic lane_b_on_ff;

   // ******************************************************
   // pin synchronisers
   // ******************************************************
   // every pin passes three flops; a new level is accepted only when the
   // second and third stage agree, so a single metastable sample never
   // reaches the conversion logic. the first stage feeds the second only.
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
         logic pin_raw;
         if (gi == `SRO_PIN_STROBE) begin : g_stb
            assign pin_raw = convert_strobe;
         end else if (gi == `SRO_PIN_PD_N) begin : g_pd
            assign pin_raw = power_down_n;
         end else if (gi == `SRO_PIN_DUAL) begin : g_dual
            assign pin_raw = dual_lane_select;
         end else if (gi == `SRO_PIN_PAT) begin : g_pat
            assign pin_raw = pattern_force;
         end else begin : g_sup
            assign pin_raw = supply_ok;
         end

         // shift chain
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               sync_ff[gi] <= '0;
            end else begin
               sync_ff[gi] <= {sync_ff[gi][STAGES-2:0], pin_raw};
            end
         end

         // agreement of the last two stages
         assign nxt_pin_lvl[gi] =
            (sync_ff[gi][1] == sync_ff[gi][2]) ? sync_ff[gi][2] :
            pin_lvl_ff[gi];
      end
   endgenerate

   // accepted levels
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_lvl_ff <= `SRO_PIN_RESET;
      end else begin
         pin_lvl_ff <= nxt_pin_lvl;
      end
   end

   assign strobe_lvl = pin_lvl_ff[`SRO_PIN_STROBE];
   assign pd_n_lvl = pin_lvl_ff[`SRO_PIN_PD_N];
   assign dual_lvl = pin_lvl_ff[`SRO_PIN_DUAL];
   assign pat_lvl = pin_lvl_ff[`SRO_PIN_PAT];
   assign supply_lvl = pin_lvl_ff[`SRO_PIN_SUPPLY];

   // ******************************************************
   // power and strobe qualification
   // ******************************************************
   // a low supply or power-down holds the core in its off state; release
   // needs no command, the state machine just walks back to idle
   assign hold_off = ~supply_lvl | ~pd_n_lvl;

   // edge memory; tracks the level even while off so that a strobe held
   // high across power-down release does not fire a conversion
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_prev_ff <= 1'b0;
      end else begin
         strobe_prev_ff <= strobe_lvl;
      end
   end

   assign strobe_rise = strobe_lvl & ~strobe_prev_ff;

   // ******************************************************
   // conversion sequencer
   // ******************************************************
   // a strobe during a running conversion is dropped: the host is bound
   // to keep the minimum conversion period, and restarting would corrupt
   // the sample being resolved
   assign conv_start = (state_ff == SRO_ST_IDLE) & strobe_rise &
                       ~hold_off;
   assign conv_done = (state_ff == SRO_ST_CONV) &
                      (conv_cnt_ff == CONV_LAST) & ~hold_off;

   always_comb begin
      nxt_state = state_ff;
      nxt_conv_cnt = conv_cnt_ff;
      case (state_ff)
         SRO_ST_OFF: begin
            nxt_conv_cnt = '0;
            if (!hold_off) begin
               nxt_state = SRO_ST_IDLE;
            end
         end
         SRO_ST_IDLE: begin
            nxt_conv_cnt = '0;
            if (conv_start) begin
               nxt_state = SRO_ST_CONV;
            end
         end
         SRO_ST_CONV: begin
            if (conv_done) begin
               nxt_state = SRO_ST_IDLE;
               nxt_conv_cnt = '0;
            end else begin
               nxt_conv_cnt = conv_cnt_ff + `SRO_CNT_W'(1);
            end
         end
         default: begin
            nxt_state = SRO_ST_OFF;
            nxt_conv_cnt = '0;
         end
      endcase
      if (hold_off) begin
         nxt_state = SRO_ST_OFF;
         nxt_conv_cnt = '0;
      end
   end

   // state and cycle count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SRO_ST_OFF;
         conv_cnt_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         conv_cnt_ff <= nxt_conv_cnt;
      end
   end

   // sample the analog code on the accepted strobe edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_ff <= '0;
      end else if (conv_start) begin
         sample_ff <= analog_code;
      end
   end

   // the result changes only at completion or on a hold off clear, so a burst still running past
   // the next strobe keeps reading the previous word until that conversion completes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_ff <= '0;
      end else if (hold_off) begin
         result_ff <= '0;
      end else if (conv_done) begin
         result_ff <= sample_ff;
      end
   end

   // ******************************************************
   // result validity
   // ******************************************************
   // counts completions since the last off period; the flag rides with
   // each result so the host knows which words to throw away
   assign nxt_done_cnt = (state_ff == SRO_ST_OFF) ? '0 :
      (conv_done && (done_cnt_ff != SUSPECT_LIMIT)) ?
      done_cnt_ff + `SRO_SUSPECT_W'(1) : done_cnt_ff;
   assign nxt_suspect = (state_ff == SRO_ST_OFF) ? 1'b1 :
      conv_done ? (done_cnt_ff != SUSPECT_LIMIT) : suspect_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_cnt_ff <= '0;
         suspect_ff <= 1'b1;
      end else begin
         done_cnt_ff <= nxt_done_cnt;
         suspect_ff <= nxt_suspect;
      end
   end

   // ******************************************************
   // output word and test pattern
   // ******************************************************
   // the pattern is picked by the current lane mode; the same msb first
   // mapping applies as for conversion data
   assign pattern_word = dual_lvl ? `SRO_PAT_DUAL : `SRO_PAT_SINGLE;
   assign nxt_word = pat_lvl ? pattern_word : result_ff;

   // mode tracking; a mode change restarts the readout bit count
   assign dual_change = dual_lvl ^ dual_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= '0;
         dual_ff <= 1'b0;
      end else begin
         word_ff <= nxt_word;
         dual_ff <= dual_lvl;
      end
   end

   // ******************************************************
   // readout domain control
   // ******************************************************
   // clear is a flop of this domain used as async reset over there; the
   // readout clock may be stopped, so only an async clear can reach it.
   // lanes_on gates lane a and echo clock while the core is off; lane_b_on_ff gates lane b.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clear_ff <= 1'b1;
         lanes_on_ff <= 1'b0;
         lane_b_on_ff <= 1'b0;
      end else begin
         clear_ff <= hold_off | dual_change;
         lanes_on_ff <= ~hold_off;
         lane_b_on_ff <= ~hold_off & dual_lvl;
      end
   end

   assign lnk.word = word_ff;
   assign lnk.dual = dual_ff;
   assign lnk.clear = clear_ff;

   sro_serializer u_ser (
      .readout_clk(readout_clk),
      .lnk(lnk.link)
   );

   // ******************************************************
   // pins
   // ******************************************************
   // echo is the readout clock itself, gated, so its edges line up with
   // the lane changes that the same edges cause
   assign echoed_clock_out = readout_clk & lanes_on_ff;
   assign echo_oe = lanes_on_ff;
   assign lane_a_out = lanes_on_ff & lnk.lane_a;
   assign lane_a_oe = lanes_on_ff;
   assign lane_b_out = lane_b_on_ff & lnk.lane_b;
   assign lane_b_oe = lane_b_on_ff;
   assign result_suspect = suspect_ff;
   assign conversion_busy = (state_ff == SRO_ST_CONV);
endmodule

// File: verification/sro_adc_assertions.sv
// checker for the converter control and serial readout core
// assumes it is bound to sro_adc_top and sees only its ports
module sro_adc_checker #(
   parameter int WORD_W = 16,
   parameter int INVALID_RESULTS = 2
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic convert_strobe,
   input wire logic power_down_n,
   input wire logic dual_lane_select,
   input wire logic supply_ok,
   input wire logic lane_a_out,
   input wire logic lane_a_oe,
   input wire logic lane_b_out,
   input wire logic lane_b_oe,
   input wire logic echoed_clock_out,
   input wire logic echo_oe,
   input wire logic result_suspect,
   input wire logic conversion_busy
);
   timeunit 1ns;
   timeprecision 100ps;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ********************
   // power and supply
   // ********************
   // six low samples cover the three synchroniser flops, the accepted
   // level flop and the output flop behind it
   AST_OFF_QUIET: assert property (!power_down_n [*6] |->
      !lane_a_oe && !echo_oe && !lane_b_oe && !conversion_busy)
      else $error("outputs active while powered down");
   // the suspect flag follows the off state one cycle later
   AST_SUPPLY_RESET: assert property (!supply_ok [*7] |->
      result_suspect && !lane_a_oe)
      else $error("no internal reset on low supply");
   AST_SUPPLY_RESUME: assert property ($rose(supply_ok) ##1
      (supply_ok && power_down_n) [*7] |-> lane_a_oe)
      else $error("no restart after supply recovered");

   // ********************
   // conversion
   // ********************
   AST_BUSY_ONE: assert property ($rose(conversion_busy) |=>
      !conversion_busy)
      else $error("conversion longer than one cycle");
   AST_STROBE_START: assert property ($rose(convert_strobe) &&
      !conversion_busy && lane_a_oe ##1 convert_strobe [*4] |->
      ##[0:3] conversion_busy)
      else $error("strobe did not start a conversion");
   AST_SUSPECT_DROP: assert property ($fell(result_suspect) |->
      $past(conversion_busy) || $past(conversion_busy, 2) ||
      $past(conversion_busy, 3))
      else $error("suspect flag fell without a result");

   // ********************
   // lanes and echo
   // ********************
   AST_B_OFF_SINGLE: assert property (!dual_lane_select [*6] |->
      !lane_b_oe)
      else $error("lane b enabled in single lane mode");
   AST_B_ON_DUAL: assert property (dual_lane_select [*6] ##0
      lane_a_oe |-> lane_b_oe)
      else $error("lane b not enabled in dual mode");
   AST_B_ZERO: assert property (!lane_b_oe |-> !lane_b_out)
      else $error("lane b data while disabled");
   AST_ECHO_GATED: assert property (!echo_oe |->
      !echoed_clock_out && !lane_a_out)
      else $error("echo or lane a active while off");

   COV_CONV: cover property ($rose(conversion_busy));
   COV_DUAL: cover property ($rose(lane_b_oe));
   COV_VALID: cover property ($fell(result_suspect));
endmodule

bind sro_adc_top sro_adc_checker #(
   .WORD_W(WORD_W),
   .INVALID_RESULTS(INVALID_RESULTS)
) u_sro_adc_checker (
   .core_clk(core_clk),
   .rst_n(rst_n),
   .convert_strobe(convert_strobe),
   .power_down_n(power_down_n),
   .dual_lane_select(dual_lane_select),
   .supply_ok(supply_ok),
   .lane_a_out(lane_a_out),
   .lane_a_oe(lane_a_oe),
   .lane_b_out(lane_b_out),
   .lane_b_oe(lane_b_oe),
   .echoed_clock_out(echoed_clock_out),
   .echo_oe(echo_oe),
   .result_suspect(result_suspect),
   .conversion_busy(conversion_busy)
);

// File: verification/sro_host_model.sv
// host side model: issues strobes and clocks results out
// assumes core_clk is the device core clock; readout clock is 15 ns
module sro_host_model (
   input wire logic core_clk,
   output logic convert_strobe,
   output logic readout_clk,
   input wire logic lane_a_out,
   input wire logic lane_b_out,
   input wire logic echoed_clock_out
);
   timeunit 1ns;
   timeprecision 100ps;
   import sro_pkg::*;

   int echo_hits = 0;

   // readout clock stands still between bursts
   initial begin
      convert_strobe = 1'b0;
      readout_clk = 1'b0;
   end

   // ********************
   // strobe and burst
   // ********************
   // long low time keeps strobes apart by more than the minimum period
   task automatic convert();
      convert_strobe = 1'b1;
      repeat (6) @(posedge core_clk);
      #2 convert_strobe = 1'b0;
      repeat (4) @(posedge core_clk);
      #2;
   endtask

   // lanes sampled just before each edge, echo checked just after
   task automatic read_word(input int pulses, input logic dual,
                            output sro_word_t w);
      w = '0;
      for (int e = 0; e < 2 * pulses; e++) begin
         #6.5;
         if (dual) begin
            w = {w[13:0], lane_a_out, lane_b_out};
         end else begin
            w = {w[14:0], lane_a_out};
         end
         readout_clk = ~readout_clk;
         #1 echo_hits += int'(echoed_clock_out === readout_clk);
      end
      #7.5;
   endtask
endmodule

// File: verification/sar_adc_serial_readout_tb.sv
// self checking bench for the converter control and readout core
// assumes the checker is bound in and the host model drives the link
module sar_adc_serial_readout_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import sro_pkg::*;

   logic core_clk, rst_n, power_down_n, dual_lane_select;
   logic pattern_force, supply_ok, convert_strobe, readout_clk;
   logic lane_a_out, lane_a_oe, lane_b_out, lane_b_oe;
   logic echoed_clock_out, echo_oe, result_suspect, conversion_busy;
   sro_word_t analog_code;
   sro_word_t got;
   sro_word_t exp_q[$];
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int done_conv = 0;
   int h0;

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   sro_adc_top u_sro_adc_top (.core_clk(core_clk), .rst_n(rst_n),
      .readout_clk(readout_clk), .convert_strobe(convert_strobe),
      .power_down_n(power_down_n), .dual_lane_select(dual_lane_select),
      .pattern_force(pattern_force), .supply_ok(supply_ok),
      .analog_code(analog_code), .lane_a_out(lane_a_out),
      .lane_a_oe(lane_a_oe), .lane_b_out(lane_b_out),
      .lane_b_oe(lane_b_oe), .echoed_clock_out(echoed_clock_out),
      .echo_oe(echo_oe), .result_suspect(result_suspect),
      .conversion_busy(conversion_busy));

   sro_host_model u_sro_host_model (.core_clk(core_clk),
      .convert_strobe(convert_strobe), .readout_clk(readout_clk),
      .lane_a_out(lane_a_out), .lane_b_out(lane_b_out),
      .echoed_clock_out(echoed_clock_out));

   // ********************
   // helpers
   // ********************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      if (err_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask

   // reference model: test word replaces data while pattern is forced
   task automatic conv(input sro_word_t code);
      @(posedge core_clk);
      #2 analog_code = code;
      if (pattern_force) begin
         exp_q.push_back(dual_lane_select ? 16'hcc3f : 16'ha07f);
      end else begin
         exp_q.push_back(code);
      end
      u_sro_host_model.convert();
      check(16'(result_suspect), 16'(done_conv < 2));
      done_conv++;
   endtask

   task automatic rd();
      int p;
      p = dual_lane_select ? 4 : 8;
      h0 = u_sro_host_model.echo_hits;
      u_sro_host_model.read_word(p, dual_lane_select, got);
      check(got, exp_q.pop_front());
      check(16'(u_sro_host_model.echo_hits - h0), 16'(2 * p));
      // realign to the core clock so the next pin change is edge based
      settle(1);
   endtask

   // hang guard, the whole run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         finish_test();
      end
   end

   // ********************
   // main sequence
   // ********************
   initial begin
      void'($urandom(88));
      rst_n = 1'b0;
      power_down_n = 1'b1;
      dual_lane_select = 1'b0;
      pattern_force = 1'b0;
      supply_ok = 1'b1;
      analog_code = '0;
      repeat (4) @(posedge core_clk);
      #2 rst_n = 1'b1;
      settle(6);
      // lane modes alternate; last two runs send the test words
      for (int n = 0; n < 8; n++) begin
         dual_lane_select = n[0];
         pattern_force = (n >= 6);
         settle(8);
         conv(16'($urandom));
         rd();
      end
      dual_lane_select = 1'b0;
      pattern_force = 1'b0;
      settle(8);
      // next strobe rises while the old word is still shifting
      conv(16'($urandom));
      fork
         rd();
         begin
            #60;
            conv(16'($urandom));
         end
      join
      rd();
      // power-down, then supply loss: strobe ignored, lanes silent
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            power_down_n = 1'b0;
         end else begin
            supply_ok = 1'b0;
         end
         settle(6);
         u_sro_host_model.convert();
         h0 = u_sro_host_model.echo_hits;
         u_sro_host_model.read_word(8, 1'b0, got);
         settle(1);
         check(got, 16'h0000);
         check(16'(u_sro_host_model.echo_hits - h0), 16'd8);
         check(16'(lane_a_oe), 16'h0000);
         check(16'(result_suspect), 16'h0001);
         power_down_n = 1'b1;
         supply_ok = 1'b1;
         done_conv = 0;
         // no reference buffer to settle here; a short wait stands in
         settle(8);
         for (int j = 0; j < 3; j++) begin
            conv(16'($urandom));
            rd();
         end
      end
      finish_test();
   end
endmodule
